// File: cmb_msg_buffer.sv
`include "cmb_params.svh"
module cmb_msg_buffer
	import cmb_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rxValid,
	input wire cmb_frame_t rxFrame,
	output logic bufEnable,
	output logic [2:0] bufMaskSel,
	output logic txReq,
	output cmb_frame_t txFrame,
	output logic [3:0] txLen,
	input wire logic txDone,
	output logic irq
);
	// ****************
	// Declarations
	// ****************
	logic awPend, wPend, doWrite, wMapped;
	logic [7:0] wAddr, rAddr, dlcReg, confReg;
	logic [31:0] wData;
	logic [3:0] wStrb;
	cmb_rd_t rdState, next_rdState;
	cmb_conf_t conf;
	logic storedFlag, transmit_request_flag;
	logic [2:0] intStat, intMask, intSet, intClr;
	logic [63:0] memAll, busData;
	logic [7:0] busByteWe, rxByteWe;
	logic rxStore, rxDiscard, rdMapped;
	logic [3:0] next_txLen;
	logic [31:0] rdMux;
	logic [3:0] pairHitW, pairHitR;
	logic [7:0] byteHitW, byteHitR;
	logic [31:0] pairRd [4];
	logic [31:0] byteRd [8];
	logic hitDlcW, hitConfW, hitCtrlW, hitStatW, hitMaskW;
	logic hitDlcR, hitConfR, hitCtrlR, hitStatR, hitMaskR;

	// ****************
	// Write channel
	// ****************
	// Address and data are latched separately so either may come first
	assign awready = ~awPend & ~bvalid;
	assign wready = ~wPend & ~bvalid;
	assign doWrite = awPend & wPend;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			awPend <= 1'b0;
			wAddr <= 8'h00;
		end else if (awvalid && awready) begin
			awPend <= 1'b1;
			wAddr <= awaddr;
		end else if (doWrite) begin
			awPend <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wPend <= 1'b0;
			wData <= 32'h0;
			wStrb <= 4'h0;
		end else if (wvalid && wready) begin
			wPend <= 1'b1;
			wData <= wdata;
			wStrb <= wstrb;
		end else if (doWrite) begin
			wPend <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= `CMB_RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= wMapped ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************
	// Address decode
	// ****************
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_pair
			assign pairHitW[i] = wAddr == 8'(`CMB_OFS_PAIR01 + 4 * i);
			assign pairHitR[i] = rAddr == 8'(`CMB_OFS_PAIR01 + 4 * i);
			assign pairRd[i] = {16'h0, memAll[16*i +: 16]};
		end
		for (i = 0; i < 8; i++) begin : g_byte
			assign byteHitW[i] = wAddr == 8'(`CMB_OFS_BYTE0 + 4 * i);
			assign byteHitR[i] = rAddr == 8'(`CMB_OFS_BYTE0 + 4 * i);
			assign byteRd[i] = {24'h0, memAll[8*i +: 8]};
			// Pair and byte views share storage
			assign busByteWe[i] = doWrite & ((pairHitW[i/2] & wStrb[i%2]) |
				(byteHitW[i] & wStrb[0]));
			assign busData[8*i +: 8] = byteHitW[i] ? wData[7:0] : wData[8*(i%2) +: 8];
		end
	endgenerate

	assign hitDlcW = wAddr == `CMB_OFS_DLC;
	assign hitConfW = wAddr == `CMB_OFS_CONF;
	assign hitCtrlW = wAddr == `CMB_OFS_CTRL;
	assign hitStatW = wAddr == `CMB_OFS_ISTAT;
	assign hitMaskW = wAddr == `CMB_OFS_IMASK;
	assign wMapped = (|pairHitW) | (|byteHitW) | hitDlcW | hitConfW | hitCtrlW |
		hitStatW | hitMaskW;
	assign hitDlcR = rAddr == `CMB_OFS_DLC;
	assign hitConfR = rAddr == `CMB_OFS_CONF;
	assign hitCtrlR = rAddr == `CMB_OFS_CTRL;
	assign hitStatR = rAddr == `CMB_OFS_ISTAT;
	assign hitMaskR = rAddr == `CMB_OFS_IMASK;
	assign rdMapped = (|pairHitR) | (|byteHitR) | hitDlcR | hitConfR | hitCtrlR |
		hitStatR | hitMaskR;

	// ****************
	// Buffer registers
	// ****************
	// Reception claims the length register over a same-cycle write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dlcReg <= `CMB_RST_DLC;
		end else if (rxStore) begin
			dlcReg <= {4'h0, rxFrame.dlc};
		end else if (doWrite && hitDlcW && wStrb[0]) begin
			// Upper four bits held at zero
			dlcReg <= wData[7:0] & `CMB_DLC_WMASK;
		end
	end

	// Reception never writes here, so a remote frame leaves the remote bit alone
	// Remote bit kept on reception
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			confReg <= `CMB_RST_CONF;
		end else if (doWrite && hitConfW && wStrb[0]) begin
			// Bits 2 and 1 kept at zero
			confReg <= wData[7:0] & `CMB_CONF_WMASK;
		end
	end

	// Type and mask selection from config
	assign conf.overwrite = confReg[`CMB_CONF_OWS];
	assign conf.remoteReq = confReg[`CMB_CONF_RTR];
	assign conf.bufType = confReg[`CMB_CONF_TYPE +: 3];
	assign conf.inUse = confReg[`CMB_CONF_INUSE];
	assign bufMaskSel = conf.bufType;

	// Set wins over the clear written in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			storedFlag <= 1'b0;
		end else if (rxStore) begin
			storedFlag <= 1'b1;
		end else if (doWrite && hitCtrlW && wStrb[0] && wData[`CMB_CTRL_STORED]) begin
			storedFlag <= 1'b0;
		end
	end

	// Software set beats a completion landing in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_request_flag <= 1'b0;
		end else if (doWrite && hitCtrlW && wStrb[0] && wData[`CMB_CTRL_TRQ]) begin
			transmit_request_flag <= 1'b1;
		end else if (txDone || (doWrite && hitCtrlW && wStrb[1] &&
			wData[`CMB_CTRL_TRQCLR])) begin
			transmit_request_flag <= 1'b0;
		end
	end

	// ****************
	// Reception
	// ****************
	cmb_rx_accept u_accept (
		.conf(conf),
		.storedFlag(storedFlag),
		.transmit_request_flag(transmit_request_flag),
		.rxValid(rxValid),
		.rxRemote(rxFrame.remote),
		.rxDlc(rxFrame.dlc),
		.bufEnable(bufEnable),
		.store(rxStore),
		.discard(rxDiscard),
		.byteWe(rxByteWe)
	);

	cmb_data_mem #(
		.BYTES(8)
	) u_mem (
		.mclk(mclk),
		.rxByteWe(rxByteWe),
		.rxData(rxFrame.data),
		.busByteWe(busByteWe),
		.busData(busData),
		.rdAll(memAll)
	);

	// ****************
	// Transmission
	// ****************
	// Only an in-use transmit buffer requests
	assign txReq = bufEnable & (conf.bufType == CMB_TX) & transmit_request_flag;
	// Remote bit chooses the frame type
	// Remote frame carries the stored code
	assign txFrame = {conf.remoteReq, dlcReg[3:0], memAll};
	// Codes 0..8 give that many bytes
	// No data bytes for a remote frame
	assign next_txLen = conf.remoteReq ? 4'h0 :
		(dlcReg[3:0] > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES : dlcReg[3:0];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txLen <= 4'h0;
		end else begin
			txLen <= next_txLen;
		end
	end

	// ****************
	// Interrupts
	// ****************
	assign intSet[`CMB_IRQ_RX] = rxStore;
	assign intSet[`CMB_IRQ_TX] = txDone;
	assign intSet[`CMB_IRQ_LOST] = rxDiscard;
	assign intClr = (doWrite && hitStatW && wStrb[0]) ? wData[2:0] : 3'h0;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intStat <= 3'h0;
		end else begin
			intStat <= (intStat & ~intClr) | intSet;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intMask <= `CMB_RST_IMASK;
		end else if (doWrite && hitMaskW && wStrb[0]) begin
			intMask <= wData[2:0];
		end
	end

	assign irq = |(intStat & intMask);

	// ****************
	// Read channel
	// ****************
	// One wait cycle lets the registered byte store settle after a write
	function automatic logic [31:0] rdSelect(
		input logic [3:0] pHit,
		input logic [7:0] bHit,
		input logic [31:0] pData [4],
		input logic [31:0] bData [8]
	);
		logic [31:0] acc;
		acc = 32'h0;
		for (int k = 0; k < 4; k++) begin
			acc = acc | ({32{pHit[k]}} & pData[k]);
		end
		for (int k = 0; k < 8; k++) begin
			acc = acc | ({32{bHit[k]}} & bData[k]);
		end
		return acc;
	endfunction

	assign rdMux = rdSelect(pairHitR, byteHitR, pairRd, byteRd) |
		({32{hitDlcR}} & {24'h0, dlcReg}) |
		({32{hitConfR}} & {24'h0, confReg}) |
		({32{hitCtrlR}} & {30'h0, storedFlag, transmit_request_flag}) |
		({32{hitStatR}} & {29'h0, intStat}) |
		({32{hitMaskR}} & {29'h0, intMask});

	assign arready = rdState == CMB_RD_IDLE;
	assign rvalid = rdState == CMB_RD_RESP;

	always_comb begin
		next_rdState = rdState;
		case (rdState)
			CMB_RD_IDLE: begin
				if (arvalid) begin
					next_rdState = CMB_RD_WAIT;
				end
			end
			CMB_RD_WAIT: begin
				next_rdState = CMB_RD_RESP;
			end
			CMB_RD_RESP: begin
				if (rready) begin
					next_rdState = CMB_RD_IDLE;
				end
			end
			default: begin
				next_rdState = CMB_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdState <= CMB_RD_IDLE;
			rAddr <= 8'h00;
		end else begin
			rdState <= next_rdState;
			if (arvalid && arready) begin
				rAddr <= araddr;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0;
			rresp <= `CMB_RESP_OKAY;
		end else if (rdState == CMB_RD_WAIT) begin
			rdata <= rdMux;
			rresp <= rdMapped ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
		end
	end
endmodule

// File: cmb_params.svh
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH
`define CMB_OFS_PAIR01 8'h00
`define CMB_OFS_BYTE0 8'h10
`define CMB_OFS_DLC 8'h30
`define CMB_OFS_CONF 8'h34
`define CMB_OFS_CTRL 8'h38
`define CMB_OFS_ISTAT 8'h3c
`define CMB_OFS_IMASK 8'h40
`define CMB_CONF_INUSE 0
`define CMB_CONF_TYPE 3
`define CMB_CONF_RTR 6
`define CMB_CONF_OWS 7
`define CMB_CONF_WMASK 8'hf9
`define CMB_DLC_WMASK 8'h0f
`define CMB_CTRL_TRQ 0
`define CMB_CTRL_STORED 1
`define CMB_CTRL_TRQCLR 8
`define CMB_IRQ_RX 0
`define CMB_IRQ_TX 1
`define CMB_IRQ_LOST 2
`define CMB_RST_DLC 8'h00
`define CMB_RST_CONF 8'h00
`define CMB_RST_IMASK 3'h0
`define CMB_MAX_BYTES 4'h8
`define CMB_RESP_OKAY 2'h0
`define CMB_RESP_SLVERR 2'h2
`endif

// File: cmb_pkg.sv
package cmb_pkg;
	typedef enum logic [2:0] {
		CMB_TX = 3'h0,
		CMB_RX_NOMASK = 3'h1,
		CMB_RX_MASK1 = 3'h2,
		CMB_RX_MASK2 = 3'h3,
		CMB_RX_MASK3 = 3'h4,
		CMB_RX_MASK4 = 3'h5
	} cmb_type_t;
	typedef struct packed {
		logic overwrite;
		logic remoteReq;
		logic [2:0] bufType;
		logic inUse;
	} cmb_conf_t;
	typedef struct packed {
		logic remote;
		logic [3:0] dlc;
		logic [63:0] data;
	} cmb_frame_t;
	typedef enum logic [1:0] {
		CMB_RD_IDLE = 2'h0,
		CMB_RD_WAIT = 2'h1,
		CMB_RD_RESP = 2'h2
	} cmb_rd_t;
endpackage

// File: cmb_data_mem.sv
`include "cmb_params.svh"
module cmb_data_mem #(
	parameter int BYTES = 8
) (
	input wire logic mclk,
	input wire logic [BYTES-1:0] rxByteWe,
	input wire logic [8*BYTES-1:0] rxData,
	input wire logic [BYTES-1:0] busByteWe,
	input wire logic [8*BYTES-1:0] busData,
	output logic [8*BYTES-1:0] rdAll
);
	// ****************
	// Byte storage
	// ****************
	// No reset: contents are undefined until written
	logic [7:0] mem [BYTES];
	genvar i;
	generate
		for (i = 0; i < BYTES; i++) begin : g_byte
			// Reception wins a same-cycle collision with software
			always_ff @(posedge mclk) begin
				if (rxByteWe[i]) begin
					mem[i] <= rxData[8*i +: 8];
				end else if (busByteWe[i]) begin
					mem[i] <= busData[8*i +: 8];
				end
			end
			always_ff @(posedge mclk) begin
				rdAll[8*i +: 8] <= mem[i];
			end
		end
	endgenerate
endmodule

// File: cmb_rx_accept.sv
`include "cmb_params.svh"
module cmb_rx_accept
	import cmb_pkg::*;
(
	input wire cmb_conf_t conf,
	input wire logic storedFlag,
	input wire logic transmit_request_flag,
	input wire logic rxValid,
	input wire logic rxRemote,
	input wire logic [3:0] rxDlc,
	output logic bufEnable,
	output logic store,
	output logic discard,
	output logic [7:0] byteWe
);
	logic isTx;
	logic isRx;
	logic remoteOk;
	logic dataOk;
	logic [3:0] nBytes;
	// Only the six legal type codes
	assign isTx = conf.bufType == CMB_TX;
	assign isRx = conf.bufType inside {CMB_RX_NOMASK, CMB_RX_MASK1, CMB_RX_MASK2,
		CMB_RX_MASK3, CMB_RX_MASK4};
	assign bufEnable = conf.inUse & (isTx | isRx);
	assign remoteOk = rxRemote & ~conf.remoteReq & ~transmit_request_flag;
	assign dataOk = ~rxRemote & isRx & (~storedFlag | conf.overwrite);
	assign store = rxValid & bufEnable & (remoteOk | dataOk);
	assign discard = rxValid & bufEnable & ~rxRemote & isRx & storedFlag & ~conf.overwrite;
	// Store received bytes, capped at eight
	assign nBytes = (rxRemote) ? 4'h0 : (rxDlc > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES : rxDlc;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_we
			assign byteWe[i] = store & (4'(i) < nBytes);
		end
	endgenerate
endmodule

// File: cmb_msg_buffer_asserts.sv
module cmb_msg_buffer_asserts
	import cmb_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic rxValid,
	input wire cmb_frame_t rxFrame,
	input wire logic bufEnable,
	input wire logic [2:0] bufMaskSel,
	input wire logic txReq,
	input wire cmb_frame_t txFrame,
	input wire logic [3:0] txLen,
	input wire logic txDone,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ****************
	// Transmit side
	// ****************
	// txLen lags the settings by one cycle
	remote_len_a: assert property ($past(txFrame.remote) |-> txLen == 4'h0)
		else $error("remote frame carries data bytes");
	data_len_a: assert property (!$past(txFrame.remote) |->
		txLen == (($past(txFrame.dlc) > 4'h8) ? 4'h8 : $past(txFrame.dlc)))
		else $error("data byte count wrong for length code");
	tx_enabled_a: assert property (txReq |-> bufEnable && bufMaskSel == 3'h0)
		else $error("request from buffer not set up for transmit");
	done_clears_a: assert property (txDone |=> !txReq)
		else $error("request still up after completion");
	// ****************
	// Receive side
	// ****************
	legal_type_a: assert property (bufEnable |-> bufMaskSel <= 3'h5)
		else $error("buffer enabled with illegal type");
	rtr_kept_a: assert property (rxValid && rxFrame.remote && !txFrame.remote |=>
		!txFrame.remote)
		else $error("remote request bit changed by reception");
	// Two cycles: irq follows storage one cycle late
	ignored_remote_a: assert property (rxValid && rxFrame.remote && txFrame.remote |=>
		$stable(irq) [*2])
		else $error("blocked remote frame signalled");
	unused_quiet_a: assert property (rxValid && !bufEnable |=> $stable(irq) [*2])
		else $error("unused buffer reacted to frame");
	cover property (txDone && txFrame.remote);
	cover property (rxValid && rxFrame.remote);
	cover property ($rose(irq));
endmodule
bind cmb_msg_buffer cmb_msg_buffer_asserts cmb_msg_buffer_asserts_inst (.mclk, .rst_n,
	.rxValid, .rxFrame, .bufEnable, .bufMaskSel, .txReq, .txFrame, .txLen, .txDone, .irq);

// File: cmb_can_node.sv
module cmb_can_node
	import cmb_pkg::*;
(
	input wire logic mclk,
	input wire logic txReq,
	input wire logic [3:0] txLen,
	output logic rxValid,
	output cmb_frame_t rxFrame,
	output logic txDone
);
	timeunit 1ns;
	timeprecision 100ps;
	int lag = 0;
	initial begin
		rxValid = 1'h0;
		rxFrame = '0;
		txDone = 1'h0;
	end
	// Idle payload inverted so stale data never looks valid
	task automatic send(input logic rem, input logic [3:0] n, input logic [63:0] dt);
		rxValid <= 1'h1;
		rxFrame <= {rem, n, dt};
		@(posedge mclk);
		rxValid <= 1'h0;
		rxFrame <= ~{rem, n, dt};
	endtask
	always begin
		@(negedge mclk);
		if (txReq) begin
			repeat (lag + int'(txLen) + 1) @(posedge mclk);
			txDone <= 1'h1;
			@(posedge mclk);
			txDone <= 1'h0;
		end
	end
endmodule

// File: tb.sv
`include "cmb_params.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb
	import cmb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, r;
	logic [3:0] wstrb = 0, txLen;
	logic awready, wready, bvalid, arready, rvalid, bufEnable, txReq, txDone, rxValid, irq;
	logic [1:0] bresp, rresp;
	logic [2:0] bufMaskSel;
	logic [7:0] unused[3] = '{8'h08, 8'h28, 8'h18};
	logic [63:0] d;
	logic [33:0] ex;
	logic [33:0] expQ[$];
	logic [1:0] exr;
	logic [1:0] respQ[$];
	cmb_frame_t rxFrame, txFrame;
	int seed = 62015;
	int fails = 0;
	int comparisons = 0;
	cmb_msg_buffer cmb_msg_buffer_inst (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .rxValid, .rxFrame, .bufEnable, .bufMaskSel, .txReq, .txFrame,
		.txLen, .txDone, .irq);
	cmb_can_node cmb_can_node_inst (.mclk, .txReq, .txLen, .rxValid, .rxFrame, .txDone);
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// ****************
	// Bus tasks
	// ****************
	// Readies sampled at negedge, so no race with the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s = 4'hf,
		input logic [1:0] rs = 2'h0);
		logic ah, wh, bh;
		@(posedge mclk);
		respQ.push_back(rs);
		awaddr <= a; wdata <= dt; wstrb <= s;
		awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
		do begin
			@(negedge mclk);
			ah = awready; wh = wready; bh = bvalid;
			@(posedge mclk);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
		end while (!bh);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rs = 2'h0);
		logic ah, vh;
		@(posedge mclk);
		expQ.push_back({rs, e});
		araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
		do begin
			@(negedge mclk);
			ah = arready; vh = rvalid;
			@(posedge mclk);
			if (ah) arvalid <= 1'h0;
		end while (!vh);
		rready <= 1'h0;
	endtask
	task automatic rx(input logic rem, input logic [3:0] n);
		d = {$random(seed), $random(seed)};
		@(posedge mclk);
		cmb_can_node_inst.send(rem, n, d);
	endtask
	task automatic tdone(input string n);
		repeat (200) if (expQ.size() != 0 || respQ.size() != 0) @(posedge mclk);
		$display("test %s finished", n);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Any result with no note left compares against unknown
	always @(negedge mclk) begin
		if (bvalid && bready) begin
			exr = (respQ.size() != 0) ? respQ.pop_front() : 'x;
			`CHK("write resp", exr, bresp)
		end
		if ((rvalid && rready) || txDone) begin
			ex = (expQ.size() != 0) ? expQ.pop_front() : 'x;
			if (txDone) `CHK("tx frame", ex, {25'h0, txFrame.remote, txFrame.dlc, txLen})
			else `CHK("read", ex, {rresp, rdata})
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test();
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		rd(`CMB_OFS_DLC, 32'h0);
		rd(`CMB_OFS_CTRL, 32'h0);
		rd(8'h44, 32'h0, `CMB_RESP_SLVERR);
		wr(8'h44, 32'h1, 4'hf, `CMB_RESP_SLVERR);
		wr(`CMB_OFS_IMASK, 32'h7);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			wr(8'(4 * i), {16'h0, r[15:0]}, 4'h3);
			rd(8'(`CMB_OFS_BYTE0 + 8 * i), {24'h0, r[7:0]});
			rd(8'(`CMB_OFS_BYTE0 + 8 * i + 4), {24'h0, r[15:8]});
		end
		wr(8'h2c, {24'h0, r[23:16]}, 4'h1);
		rd(8'h0c, {16'h0, r[23:16], r[7:0]});
		tdone("pairs");
		wr(`CMB_OFS_CONF, 32'h9);
		wr(`CMB_OFS_DLC, 32'h5);
		rx(1'h0, 4'h3);
		rd(`CMB_OFS_DLC, 32'h3);
		rd(`CMB_OFS_CTRL, 32'h2);
		rd(`CMB_OFS_PAIR01, {16'h0, d[15:0]});
		rd(8'h18, {24'h0, d[23:16]});
		r = d[31:0];
		rx(1'h0, 4'h8);
		rd(`CMB_OFS_PAIR01, {16'h0, r[15:0]});
		rd(`CMB_OFS_ISTAT, 32'h5);
		wr(`CMB_OFS_ISTAT, 32'h7);
		wr(`CMB_OFS_CONF, 32'h89);
		rx(1'h0, 4'hc);
		rd(`CMB_OFS_DLC, 32'hc);
		for (int i = 0; i < 4; i++) rd(8'(4 * i), {16'h0, d[16 * i +: 16]});
		wr(`CMB_OFS_CONF, 32'h9);
		rx(1'h1, 4'h2);
		rd(`CMB_OFS_DLC, 32'h2);
		rd(`CMB_OFS_ISTAT, 32'h1);
		wr(`CMB_OFS_ISTAT, 32'h7);
		foreach (unused[i]) begin
			wr(`CMB_OFS_CONF, {24'h0, unused[i]});
			rx(1'h0, 4'h1);
			rd(`CMB_OFS_ISTAT, 32'h0);
		end
		tdone("receive");
		for (int t = 0; t < 6; t++) begin
			wr(`CMB_OFS_CONF, {24'h0, 2'h3, 3'(t), 3'h1});
			rd(`CMB_OFS_CONF, {24'h0, 2'h3, 3'(t), 3'h1});
		end
		for (int k = 0; k < 16; k++) begin
			cmb_can_node_inst.lag = k % 4;
			wr(`CMB_OFS_DLC, 32'(k));
			wr(`CMB_OFS_CONF, (k % 3 == 0) ? 32'h41 : 32'h1);
			expQ.push_back({25'h0, k % 3 == 0, 4'(k),
				(k % 3 == 0) ? 4'h0 : ((k > 8) ? 4'h8 : 4'(k))});
			wr(`CMB_OFS_CTRL, 32'h1);
			tdone("transmit");
		end
		wr(`CMB_OFS_ISTAT, 32'h7);
		wr(`CMB_OFS_CONF, 32'h1);
		rx(1'h1, 4'h4);
		rd(`CMB_OFS_CONF, 32'h1);
		rd(`CMB_OFS_DLC, 32'h4);
		wr(`CMB_OFS_CONF, 32'h41);
		wr(`CMB_OFS_CTRL, 32'h2);
		wr(`CMB_OFS_ISTAT, 32'h7);
		rx(1'h1, 4'h6);
		rd(`CMB_OFS_DLC, 32'h4);
		rd(`CMB_OFS_CTRL, 32'h0);
		rd(`CMB_OFS_ISTAT, 32'h0);
		tdone("remote");
		end_of_test();
	end
endmodule
